// [core/drss_seq.v]
// Function
// - Legacy strategy 9 does the strategy 1 reset, then maps flash to zero.
// - Every microcontroller strategy works on JTAG and SWD and ends with core halted.
// - Strategy 0 acts as 8, or halts after bootloader when device needs it.
// - Arm core reset vector catch before a core-and-peripheral reset.
// - Then trigger the reset with the system reset request bit.
// - Poll reset sticky status high then low, then clear vector catch.
// - Strategy 1 resets core only, vector catch armed, waits sticky rise and fall.
// - Strategy 2 pulls reset pin low after arming catch; fails if pin stays high.
// - Strategy 3 holds reset pin low while enabling debug and arming catch, then releases it.
// - Strategy 4 lets bootloader run and halts right after it.
// - Strategy 5 resets and halts immediately, like strategy 8.
// - Strategy 6 does strategy 8 reset, then disables the watchdog once halted.
// - Strategy 7 resets by system request and halts after the vendor kernel.
// - Strategy 9 halts after bootloader, disables watchdog; needs link clock of 1 MHz.
// - Strategy 10 resets with vector catch armed, then disables the watchdog.
// - Legacy strategy 1 sets a breakpoint at zero before pulsing the reset pin.
`timescale 1ns/1ps
`include "drss_defines.vh"
module drss_seq #(
   parameter [15:0] ACC_TO_CYC       = `DRSS_ACC_TO_CYC,
   parameter [10:0] POLL_MAX         = `DRSS_POLL_MAX,
   parameter [15:0] RST_PULSE_CYC    = `DRSS_RST_PULSE_CYC,
   parameter [15:0] LINK_MAX_PER_CYC = `DRSS_LINK_MAX_PER_CYC,
   parameter [31:0] WDOG_ADDR        = `DRSS_WDOG_ADDR,
   parameter [31:0] WDOG_DIS_VAL     = `DRSS_WDOG_DIS_VAL,
   parameter [31:0] MEMORY_MAP_SELECT_ADDR      = `DRSS_MEMORY_MAP_SELECT_ADDR,
   parameter [31:0] MEMORY_MAP_SELECT_FLASH_VAL = `DRSS_MEMORY_MAP_SELECT_FLASH_VAL,
   parameter [31:0] LEG_BP_ADDR_REG  = `DRSS_LEG_BP_ADDR_REG,
   parameter [31:0] LEG_BP_CTRL_REG  = `DRSS_LEG_BP_CTRL_REG,
   parameter [31:0] LEG_BP_EN_VAL    = `DRSS_LEG_BP_EN_VAL,
   parameter [31:0] LEG_STAT_ADDR    = `DRSS_LEG_STAT_ADDR,
   parameter [31:0] LEG_HALT_MASK    = `DRSS_LEG_HALT_MASK,
   parameter [31:0] MCU_BP_COMP_ADDR = `DRSS_MCU_BP_COMP_ADDR,
   parameter [31:0] MCU_BP_CTRL_ADDR = `DRSS_MCU_BP_CTRL_ADDR,
   parameter [31:0] MCU_BP_EN_VAL    = `DRSS_MCU_BP_EN_VAL
) (
   input  wire        CLK_SYS,
   input  wire        RSTN,
   input  wire        START,
   input  wire [3:0]  STRATEGY,
   input  wire        PROFILE_LEGACY,
   input  wire        DEV_BOOT_DBG,
   input  wire        LINK_SWD,
   input  wire [31:0] APP_ENTRY,
   input  wire        LINK_CLK,
   input  wire        ACC_ACK,
   input  wire [31:0] ACC_RDATA,
   input  wire        RST_SENSE,
   output reg         LINK_SEL_SWD,
   output reg         ACC_REQ,
   output reg         ACC_WR,
   output reg  [31:0] ACC_ADDR,
   output reg  [31:0] ACC_WDATA,
   output reg         NRST_O,
   output reg         NRST_OE_N,
   output reg         BUSY,
   output reg         DONE,
   output reg         FAIL,
   output reg  [2:0]  FAIL_CODE,
   output reg         LINK_SLOW
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_STEP = 5'h02;
   localparam [4:0] ST_ACK  = 5'h04;
   localparam [4:0] ST_REL  = 5'h08;
   localparam [4:0] ST_DLY  = 5'h10;

   localparam [2:0] OP_WR    = 3'h0;
   localparam [2:0] OP_POLL  = 3'h1;
   localparam [2:0] OP_PINLO = 3'h2;
   localparam [2:0] OP_PINHI = 3'h3;
   localparam [2:0] OP_DLY   = 3'h4;
   localparam [2:0] OP_CHK   = 3'h5;

   localparam [4:0] STEP_END = 5'h10;

   reg         rst_meta_q;
   reg         rst_n;
   wire [2:0]  sync_q;
   wire        link_clk_s = sync_q[2];
   wire        ack_s      = sync_q[1];
   wire        sense_s    = sync_q[0];

   reg  [4:0]  state_q;
   reg  [4:0]  step_q;
   reg  [15:0] cnt_q;
   reg  [10:0] poll_q;
   reg  [31:0] rdata_q;
   reg         mcu_q;
   reg         k_sys_q;
   reg         k_vect_q;
   reg         k_pin_q;
   reg         k_cur_q;
   reg         vc_q;
   reg         boot_q;
   reg         wdog_q;
   reg         memory_map_select_q;
   reg         link_prev_q;
   reg  [15:0] link_cnt_q;

   reg         s_en;
   reg  [2:0]  s_op;
   reg  [31:0] s_addr;
   reg  [31:0] s_data;
   reg  [31:0] s_mask;
   reg         s_val;

   wire        legacy_ok = (STRATEGY == `DRSS_STRAT_CORE) || (STRATEGY == `DRSS_STRAT_NINE);
   wire        boot_pick = (STRATEGY == `DRSS_STRAT_AFTER_BOOT) || (STRATEGY == `DRSS_STRAT_AFTER_KERNEL) ||
                           (STRATEGY == `DRSS_STRAT_NINE) || ((STRATEGY == `DRSS_STRAT_NORMAL) && DEV_BOOT_DBG);
   wire        poll_hit  = ((rdata_q & s_mask) != 32'h00000000) == s_val;

   always @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   drss_sync #(
      .W (3)
   ) u_sync (
      .clk   (CLK_SYS),
      .rst_n (rst_n),
      .d     ({LINK_CLK, ACC_ACK, RST_SENSE}),
      .q     (sync_q)
   );

   // Link clock period check: a period at or above the limit means the link runs at or below 1 MHz.
   // The flag only updates on a rising edge, so a link clock that stops between frames keeps its last verdict.
   always @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link_prev_q <= 1'b0;
         link_cnt_q  <= 16'h0000;
         LINK_SLOW   <= 1'b0;
      end
      else
      begin
         link_prev_q <= link_clk_s;
         if (link_clk_s && !link_prev_q)
         begin
            LINK_SLOW  <= (link_cnt_q >= LINK_MAX_PER_CYC);
            link_cnt_q <= 16'h0001;
         end
         else if (link_cnt_q != 16'hFFFF)
         begin
            link_cnt_q <= link_cnt_q + 16'h0001;
         end
      end
   end

   // Fixed step list; each strategy enables the subset it needs.
   always @*
   begin
      s_en   = 1'b0;
      s_op   = OP_WR;
      s_addr = 32'h00000000;
      s_data = 32'h00000000;
      s_mask = 32'h00000000;
      s_val  = 1'b1;
      case (step_q)
         5'h00:
         begin
            s_en = k_cur_q;
            s_op = OP_PINLO;
         end
         5'h01:
         begin
            s_en   = 1'b1;
            s_addr = mcu_q ? `DRSS_DBG_HALT_CTRL_STATUS_ADDR : LEG_BP_ADDR_REG;
            s_data = mcu_q ? (`DRSS_DBG_KEY | `DRSS_DBG_ENABLE) : 32'h00000000;
         end
         5'h02:
         begin
            s_en   = vc_q || !mcu_q;
            s_addr = mcu_q ? `DRSS_DBG_EXC_MON_CTRL_ADDR : LEG_BP_CTRL_REG;
            s_data = mcu_q ? `DRSS_CORE_RESET_VC : LEG_BP_EN_VAL;
         end
         5'h03:
         begin
            s_en   = boot_q;
            s_addr = MCU_BP_COMP_ADDR;
            s_data = {APP_ENTRY[31:1], 1'b1};
         end
         5'h04:
         begin
            s_en   = boot_q;
            s_addr = MCU_BP_CTRL_ADDR;
            s_data = MCU_BP_EN_VAL;
         end
         5'h05:
         begin
            s_en   = k_sys_q || k_vect_q;
            s_addr = `DRSS_APP_INT_RESET_CTRL_ADDR;
            s_data = `DRSS_VECT_KEY | (k_vect_q ? `DRSS_CORE_ONLY_RESET_REQ : `DRSS_SYSTEM_RESET_REQ);
         end
         5'h06:
         begin
            s_en = k_pin_q || !mcu_q;
            s_op = OP_PINLO;
         end
         5'h07:
         begin
            s_en = k_pin_q || k_cur_q || !mcu_q;
            s_op = OP_DLY;
         end
         5'h08:
         begin
            s_en = k_pin_q;
            s_op = OP_CHK;
         end
         5'h09:
         begin
            s_en = k_pin_q || k_cur_q || !mcu_q;
            s_op = OP_PINHI;
         end
         5'h0A:
         begin
            s_en   = mcu_q;
            s_op   = OP_POLL;
            s_addr = `DRSS_DBG_HALT_CTRL_STATUS_ADDR;
            s_mask = `DRSS_RESET_STICKY_MASK;
            s_val  = 1'b1;
         end
         5'h0B:
         begin
            s_en   = mcu_q;
            s_op   = OP_POLL;
            s_addr = `DRSS_DBG_HALT_CTRL_STATUS_ADDR;
            s_mask = `DRSS_RESET_STICKY_MASK;
            s_val  = 1'b0;
         end
         5'h0C:
         begin
            s_en   = 1'b1;
            s_op   = OP_POLL;
            s_addr = mcu_q ? `DRSS_DBG_HALT_CTRL_STATUS_ADDR : LEG_STAT_ADDR;
            s_mask = mcu_q ? `DRSS_HALTED_MASK : LEG_HALT_MASK;
            s_val  = 1'b1;
         end
         5'h0D:
         begin
            s_en   = vc_q;
            s_addr = `DRSS_DBG_EXC_MON_CTRL_ADDR;
         end
         5'h0E:
         begin
            s_en   = wdog_q;
            s_addr = WDOG_ADDR;
            s_data = WDOG_DIS_VAL;
         end
         5'h0F:
         begin
            s_en   = memory_map_select_q;
            s_addr = MEMORY_MAP_SELECT_ADDR;
            s_data = MEMORY_MAP_SELECT_FLASH_VAL;
         end
         default:
         begin
            s_en = 1'b0;
         end
      endcase
   end

   always @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q      <= ST_IDLE;
         step_q       <= 5'h00;
         cnt_q        <= 16'h0000;
         poll_q       <= 11'h000;
         rdata_q      <= 32'h00000000;
         mcu_q        <= 1'b0;
         k_sys_q      <= 1'b0;
         k_vect_q     <= 1'b0;
         k_pin_q      <= 1'b0;
         k_cur_q      <= 1'b0;
         vc_q         <= 1'b0;
         boot_q       <= 1'b0;
         wdog_q       <= 1'b0;
         memory_map_select_q     <= 1'b0;
         LINK_SEL_SWD <= 1'b0;
         ACC_REQ      <= 1'b0;
         ACC_WR       <= 1'b0;
         ACC_ADDR     <= 32'h00000000;
         ACC_WDATA    <= 32'h00000000;
         NRST_O       <= 1'b0;
         NRST_OE_N    <= 1'b1;
         BUSY         <= 1'b0;
         DONE         <= 1'b0;
         FAIL         <= 1'b0;
         FAIL_CODE    <= `DRSS_FAIL_NONE;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (START)
               begin
                  DONE         <= 1'b0;
                  FAIL         <= 1'b0;
                  FAIL_CODE    <= `DRSS_FAIL_NONE;
                  LINK_SEL_SWD <= LINK_SWD;
                  mcu_q        <= !PROFILE_LEGACY;
                  k_vect_q     <= !PROFILE_LEGACY && (STRATEGY == `DRSS_STRAT_CORE);
                  k_pin_q      <= !PROFILE_LEGACY && (STRATEGY == `DRSS_STRAT_PIN);
                  k_cur_q      <= !PROFILE_LEGACY && (STRATEGY == `DRSS_STRAT_CUR);
                  k_sys_q      <= !PROFILE_LEGACY && (STRATEGY >= `DRSS_STRAT_AFTER_BOOT ||
                                                      STRATEGY == `DRSS_STRAT_NORMAL);
                  boot_q       <= !PROFILE_LEGACY && boot_pick;
                  vc_q         <= !PROFILE_LEGACY && !boot_pick;
                  wdog_q       <= !PROFILE_LEGACY && (STRATEGY == `DRSS_STRAT_WDOG_NORMAL ||
                                                      STRATEGY == `DRSS_STRAT_NINE ||
                                                      STRATEGY == `DRSS_STRAT_WDOG_VC);
                  memory_map_select_q     <= PROFILE_LEGACY && (STRATEGY == `DRSS_STRAT_NINE);
                  step_q       <= 5'h00;
                  poll_q       <= 11'h000;
                  if (PROFILE_LEGACY ? !legacy_ok : (STRATEGY > `DRSS_STRAT_WDOG_VC))
                  begin
                     FAIL      <= 1'b1;
                     FAIL_CODE <= `DRSS_FAIL_UNSUPPORTED;
                  end
                  else
                  begin
                     BUSY    <= 1'b1;
                     state_q <= ST_STEP;
                  end
               end
            end
            ST_STEP:
            begin
               cnt_q <= 16'h0000;
               if (step_q == STEP_END)
               begin
                  BUSY    <= 1'b0;
                  DONE    <= 1'b1;
                  state_q <= ST_IDLE;
               end
               else if (!s_en)
               begin
                  step_q <= step_q + 5'h01;
               end
               else
               begin
                  case (s_op)
                     OP_WR, OP_POLL:
                     begin
                        ACC_REQ   <= 1'b1;
                        ACC_WR    <= (s_op == OP_WR);
                        ACC_ADDR  <= s_addr;
                        ACC_WDATA <= s_data;
                        state_q   <= ST_ACK;
                     end
                     OP_PINLO:
                     begin
                        NRST_OE_N <= 1'b0;
                        step_q    <= step_q + 5'h01;
                     end
                     OP_PINHI:
                     begin
                        NRST_OE_N <= 1'b1;
                        step_q    <= step_q + 5'h01;
                     end
                     OP_DLY:
                     begin
                        state_q <= ST_DLY;
                     end
                     OP_CHK:
                     begin
                        if (sense_s)
                        begin
                           NRST_OE_N <= 1'b1;
                           BUSY      <= 1'b0;
                           FAIL      <= 1'b1;
                           FAIL_CODE <= `DRSS_FAIL_PIN_STUCK;
                           state_q   <= ST_IDLE;
                        end
                        else
                        begin
                           step_q <= step_q + 5'h01;
                        end
                     end
                     default:
                     begin
                        step_q <= step_q + 5'h01;
                     end
                  endcase
               end
            end
            ST_ACK, ST_REL:
            begin
               cnt_q <= cnt_q + 16'h0001;
               if ((state_q == ST_ACK) && ack_s)
               begin
                  rdata_q <= ACC_RDATA;
                  ACC_REQ <= 1'b0;
                  cnt_q   <= 16'h0000;
                  state_q <= ST_REL;
               end
               else if ((state_q == ST_REL) && !ack_s)
               begin
                  state_q <= ST_STEP;
                  if ((s_op == OP_WR) || poll_hit)
                  begin
                     step_q <= step_q + 5'h01;
                     poll_q <= 11'h000;
                  end
                  else if (poll_q == POLL_MAX - 11'h001)
                  begin
                     NRST_OE_N <= 1'b1;
                     BUSY      <= 1'b0;
                     FAIL      <= 1'b1;
                     FAIL_CODE <= `DRSS_FAIL_POLL_TIMEOUT;
                     state_q   <= ST_IDLE;
                  end
                  else
                  begin
                     poll_q <= poll_q + 11'h001;
                  end
               end
               else if (cnt_q == ACC_TO_CYC - 16'h0001)
               begin
                  // A lost debug port (e.g. low power) must not hang the sequencer.
                  ACC_REQ   <= 1'b0;
                  NRST_OE_N <= 1'b1;
                  BUSY      <= 1'b0;
                  FAIL      <= 1'b1;
                  FAIL_CODE <= `DRSS_FAIL_ACC_TIMEOUT;
                  state_q   <= ST_IDLE;
               end
            end
            ST_DLY:
            begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == RST_PULSE_CYC - 16'h0001)
               begin
                  step_q  <= step_q + 5'h01;
                  state_q <= ST_STEP;
               end
            end
            default:
            begin
               ACC_REQ <= 1'b0;
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// [core/drss_defines.vh]
`ifndef DRSS_DEFINES_VH
`define DRSS_DEFINES_VH

// Counts in 5 ns system clock cycles: link period limit 1 us, reset pulse 1 us, access timeout 100 us.
`define DRSS_LINK_MAX_PER_CYC    16'h00C8
`define DRSS_RST_PULSE_CYC       16'h00C8
`define DRSS_ACC_TO_CYC          16'h4E20
`define DRSS_POLL_MAX            11'h3E8

// Target debug register map.
`define DRSS_DBG_HALT_CTRL_STATUS_ADDR  32'hE000EDF0
`define DRSS_DBG_EXC_MON_CTRL_ADDR      32'hE000EDFC
`define DRSS_APP_INT_RESET_CTRL_ADDR    32'hE000ED0C
`define DRSS_DBG_KEY                    32'hA05F0000
`define DRSS_DBG_ENABLE                 32'h00000001
`define DRSS_RESET_STICKY_MASK          32'h02000000
`define DRSS_HALTED_MASK                32'h00020000
`define DRSS_CORE_RESET_VC              32'h00000001
`define DRSS_VECT_KEY                   32'h05FA0000
`define DRSS_SYSTEM_RESET_REQ           32'h00000004
`define DRSS_CORE_ONLY_RESET_REQ        32'h00000001
`define DRSS_MCU_BP_COMP_ADDR           32'hE0002008
`define DRSS_MCU_BP_CTRL_ADDR           32'hE0002000
`define DRSS_MCU_BP_EN_VAL              32'h00000003
`define DRSS_LEG_BP_ADDR_REG            32'h00000000
`define DRSS_LEG_BP_CTRL_REG            32'h00000004
`define DRSS_LEG_BP_EN_VAL              32'h00000001
`define DRSS_LEG_STAT_ADDR              32'h00000008
`define DRSS_LEG_HALT_MASK              32'h00000001
`define DRSS_WDOG_ADDR                  32'h00000010
`define DRSS_WDOG_DIS_VAL               32'h00000000
`define DRSS_MEMORY_MAP_SELECT_ADDR                32'h00000014
`define DRSS_MEMORY_MAP_SELECT_FLASH_VAL           32'h00000001

// Strategy numbers.
`define DRSS_STRAT_NORMAL        4'h0
`define DRSS_STRAT_CORE          4'h1
`define DRSS_STRAT_PIN           4'h2
`define DRSS_STRAT_CUR           4'h3
`define DRSS_STRAT_AFTER_BOOT    4'h4
`define DRSS_STRAT_BEFORE_BOOT   4'h5
`define DRSS_STRAT_WDOG_NORMAL   4'h6
`define DRSS_STRAT_AFTER_KERNEL  4'h7
`define DRSS_STRAT_CORE_PERIPH   4'h8
`define DRSS_STRAT_NINE          4'h9
`define DRSS_STRAT_WDOG_VC       4'hA

// Failure codes.
`define DRSS_FAIL_NONE           3'h0
`define DRSS_FAIL_UNSUPPORTED    3'h1
`define DRSS_FAIL_ACC_TIMEOUT    3'h2
`define DRSS_FAIL_POLL_TIMEOUT   3'h3
`define DRSS_FAIL_PIN_STUCK      3'h4

`endif

// [core/drss_sync.v]
`timescale 1ns/1ps
module drss_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_q;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= {W{1'b0}};
         q      <= {W{1'b0}};
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// [sim/drss_seq_props.sv]
`timescale 1ns/1ps
module drss_seq_props (
   input wire        CLK_SYS,
   input wire        RSTN,
   input wire        START,
   input wire [3:0]  STRATEGY,
   input wire        PROFILE_LEGACY,
   input wire        LINK_SWD,
   input wire        ACC_REQ,
   input wire        ACC_WR,
   input wire [31:0] ACC_ADDR,
   input wire [31:0] ACC_WDATA,
   input wire        NRST_O,
   input wire        NRST_OE_N,
   input wire        BUSY,
   input wire        DONE,
   input wire        FAIL,
   input wire [2:0]  FAIL_CODE,
   input wire        LINK_SEL_SWD,
   input wire        LINK_SLOW
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   wire ok = PROFILE_LEGACY ? (STRATEGY == 4'h1 || STRATEGY == 4'h9) : (STRATEGY <= 4'hA);
   a_start_busy: assert property (START && !BUSY && ok |=> BUSY && !DONE && !FAIL)
      else $error("accepted start did not begin a sequence");
   a_unsup_fail: assert property (START && !BUSY && !ok |=> FAIL && FAIL_CODE == 3'h1 && !BUSY)
      else $error("unsupported strategy not refused");
   a_link_copy: assert property (START && !BUSY && ok |=> LINK_SEL_SWD == $past(LINK_SWD))
      else $error("link select not taken at start");
   a_req_hold: assert property (ACC_REQ && $past(ACC_REQ) |-> $stable({ACC_WR, ACC_ADDR, ACC_WDATA}))
      else $error("access request changed while pending");
   a_req_busy: assert property (ACC_REQ |-> BUSY)
      else $error("access outside a sequence");
   a_end_verdict: assert property ($fell(BUSY) |-> DONE != FAIL)
      else $error("sequence ended without one verdict");
   a_idle_pin: assert property (!BUSY ##1 !BUSY |-> NRST_OE_N && NRST_O == 1'b0)
      else $error("reset pin pulled while idle");
   a_fail_code: assert property (FAIL |-> FAIL_CODE != 3'h0 && !DONE)
      else $error("failure without a code");
   // The bound suits the shortened access timeout used in simulation.
   a_req_bound: assert property ($rose(ACC_REQ) |-> ##[1:60] !ACC_REQ)
      else $error("access request never ended");
   c_done: cover property ($fell(BUSY) && DONE);
   c_pin_fail: cover property (FAIL && FAIL_CODE == 3'h4);
   c_slow: cover property ($rose(LINK_SLOW));
endmodule

// [sim/drss_tgt_model.sv]
`timescale 1ns/1ps
module drss_tgt_model (
   input  wire        clk,
   input  wire        clr,
   input  wire        mute,
   input  wire        no_sticky,
   input  wire        pin_stuck,
   input  wire        slow,
   input  wire        req,
   input  wire        wr,
   input  wire [31:0] addr,
   input  wire [31:0] wdata,
   input  wire        oe_n,
   output reg         ack,
   output wire [31:0] rdata,
   output wire        sense
);
   reg [31:0] rd_q, bpv;
   reg [4:0]  cnt_q;
   reg [1:0]  sp_q;
   reg        vc_q, oe_q, first_q;
   reg        vc_rst, sys_rst, core_rst, vc_clr, wd, mm, bp0, pin, oe_w1;
   // Released read data shows the inverse, so a stale capture never matches.
   assign rdata = ack ? rd_q : ~rd_q;
   // The reset line has a pull-up; a broken pin ignores the probe.
   assign sense = pin_stuck | oe_n;
   always @(posedge clk)
   begin
      oe_q <= oe_n;
      if (clr)
      begin
         {vc_rst, sys_rst, core_rst, vc_clr, wd, mm, bp0, pin, oe_w1} <= 9'h000;
         {ack, vc_q, first_q, sp_q, cnt_q} <= 10'h080;
         bpv <= 32'h00000000;
         rd_q <= 32'h00000000;
      end
      else
      begin
         if (oe_q && !oe_n)
         begin
            pin <= 1'b1;
            vc_rst <= vc_q;
            sp_q <= no_sticky ? 2'h0 : 2'h1;
         end
         if (!req)
         begin
            ack <= 1'b0;
            cnt_q <= 5'h00;
         end
         else if (!ack && !mute && cnt_q == (slow ? 5'h14 : 5'h01))
         begin
            ack <= 1'b1;
            first_q <= 1'b0;
            if (wr)
            begin
               if (first_q) oe_w1 <= !oe_n;
               if (addr == 32'hE000EDFC) vc_q <= wdata[0];
               if (addr == 32'hE000EDFC && !wdata[0] && sp_q == 2'h2) vc_clr <= 1'b1;
               if (addr == 32'hE000ED0C)
               begin
                  vc_rst <= vc_q;
                  sys_rst <= wdata == 32'h05FA0004;
                  core_rst <= wdata == 32'h05FA0001;
                  sp_q <= no_sticky ? 2'h0 : 2'h1;
               end
               if (addr == 32'h00000010 && wdata == 32'h00000000) wd <= 1'b1;
               if (addr == 32'h00000014 && wdata == 32'h00000001) mm <= 1'b1;
               if (addr == 32'h00000000 && wdata == 32'h00000000) bp0 <= 1'b1;
               if (addr == 32'hE0002008) bpv <= wdata;
            end
            else if (addr == 32'hE000EDF0)
            begin
               // Sticky status reads high once after a reset, then halted is reported.
               rd_q <= (sp_q == 2'h1) ? 32'h02000000 : 32'h00020000;
               if (sp_q == 2'h1) sp_q <= 2'h2;
            end
            else rd_q <= 32'h00000001;
         end
         else if (!ack) cnt_q <= cnt_q + 5'h01;
      end
   end
endmodule

// [sim/drss_seq_tb_top.sv]
`timescale 1ns/1ps
module drss_seq_tb_top;
   reg         CLK_SYS = 0, RSTN = 0, START = 0, PROFILE_LEGACY = 0, DEV_BOOT_DBG = 0, LINK_SWD = 0, LINK_CLK = 0;
   reg  [3:0]  STRATEGY = 4'h0;
   reg  [31:0] APP_ENTRY = 32'h00001234;
   reg         clr = 1, mute = 0, no_sticky = 0, pin_stuck = 0, slow = 0;
   wire        ACC_ACK, RST_SENSE, LINK_SEL_SWD, ACC_REQ, ACC_WR, NRST_O, NRST_OE_N, BUSY, DONE, FAIL, LINK_SLOW;
   wire [31:0] ACC_RDATA, ACC_ADDR, ACC_WDATA;
   wire [2:0]  FAIL_CODE;
   real        lhalf = 24.0;
   integer     miscompares = 0, num_checks = 0, i;
   localparam [10:0] VCM = 11'h567, SYSM = 11'h7F1, WDM = 11'h640, BPM = 11'h290;
   always #2.5 CLK_SYS = ~CLK_SYS;
   always #(lhalf) LINK_CLK = ~LINK_CLK;
   drss_seq #(.ACC_TO_CYC(16'd50), .POLL_MAX(11'd4), .RST_PULSE_CYC(16'd4)) drss_seq_inst (
      .CLK_SYS(CLK_SYS), .RSTN(RSTN), .START(START), .STRATEGY(STRATEGY), .PROFILE_LEGACY(PROFILE_LEGACY),
      .DEV_BOOT_DBG(DEV_BOOT_DBG), .LINK_SWD(LINK_SWD), .APP_ENTRY(APP_ENTRY), .LINK_CLK(LINK_CLK),
      .ACC_ACK(ACC_ACK), .ACC_RDATA(ACC_RDATA), .RST_SENSE(RST_SENSE), .LINK_SEL_SWD(LINK_SEL_SWD),
      .ACC_REQ(ACC_REQ), .ACC_WR(ACC_WR), .ACC_ADDR(ACC_ADDR), .ACC_WDATA(ACC_WDATA), .NRST_O(NRST_O),
      .NRST_OE_N(NRST_OE_N), .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL), .FAIL_CODE(FAIL_CODE), .LINK_SLOW(LINK_SLOW));
   drss_tgt_model drss_tgt_model_inst (
      .clk(CLK_SYS), .clr(clr), .mute(mute), .no_sticky(no_sticky), .pin_stuck(pin_stuck), .slow(slow),
      .req(ACC_REQ), .wr(ACC_WR), .addr(ACC_ADDR), .wdata(ACC_WDATA), .oe_n(NRST_OE_N), .ack(ACC_ACK),
      .rdata(ACC_RDATA), .sense(RST_SENSE));
   task chk(input [31:0] got, input [31:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task run(input [3:0] s, input lg, input bd, input ig, input [2:0] flt, input [2:0] code);
      integer n;
   begin
      @(posedge CLK_SYS);
      clr <= 1'b1;
      {START, STRATEGY, PROFILE_LEGACY, DEV_BOOT_DBG, LINK_SWD, slow} <= {1'b1, s, lg, bd, s[0], s[1]};
      {mute, no_sticky, pin_stuck} <= flt;
      @(posedge CLK_SYS);
      clr <= 1'b0;
      START <= ig;
      if (ig) STRATEGY <= 4'hC;
      @(posedge CLK_SYS);
      START <= 1'b0;
      n = 0;
      #1;
      while (BUSY === 1'b1 && n < 5000)
      begin
         @(posedge CLK_SYS);
         #1;
         n = n + 1;
      end
      chk({DONE, FAIL, FAIL_CODE}, (code == 3'h0) ? 5'h10 : {2'h1, code});
   end
   endtask
   task t_mcu(input [3:0] s, input bd);
      reg v;
   begin
      v = bd ? 1'b0 : VCM[s];
      run(s, 1'b0, bd, 1'b0, 3'h0, 3'h0);
      chk(LINK_SEL_SWD, s[0]);
      if (s != 4'h3) chk(drss_tgt_model_inst.vc_rst, v);
      chk(drss_tgt_model_inst.sys_rst, SYSM[s]);
      chk(drss_tgt_model_inst.core_rst, s == 4'h1);
      chk(drss_tgt_model_inst.oe_w1, s == 4'h3);
      if (v) chk(drss_tgt_model_inst.vc_clr, 1'b1);
      chk(drss_tgt_model_inst.wd, WDM[s]);
      chk(drss_tgt_model_inst.bpv, (BPM[s] | bd) ? {APP_ENTRY[31:1], 1'b1} : 32'h0);
      $display("mcu strategy %0d boot %0d done", s, bd);
   end
   endtask
   task t_leg(input [3:0] s);
   begin
      run(s, 1'b1, 1'b0, 1'b0, 3'h0, 3'h0);
      chk({drss_tgt_model_inst.bp0, drss_tgt_model_inst.pin, drss_tgt_model_inst.mm}, {2'h3, s == 4'h9});
      $display("legacy strategy %0d done", s);
   end
   endtask
   task t_fail;
   begin
      run(4'h8, 1'b0, 1'b0, 1'b0, 3'h4, 3'h2);
      run(4'h8, 1'b0, 1'b0, 1'b0, 3'h2, 3'h3);
      run(4'h2, 1'b0, 1'b0, 1'b0, 3'h1, 3'h4);
      chk(NRST_OE_N, 1'b1);
      run(4'hC, 1'b0, 1'b0, 1'b0, 3'h0, 3'h1);
      run(4'h5, 1'b1, 1'b0, 1'b0, 3'h0, 3'h1);
      run(4'h8, 1'b0, 1'b0, 1'b1, 3'h0, 3'h0);
      $display("fault tests done");
   end
   endtask
   task t_link;
   begin
      chk(LINK_SLOW, 1'b0);
      lhalf = 1200.0;
      repeat (2000) @(posedge CLK_SYS);
      #1;
      chk(LINK_SLOW, 1'b1);
      run(4'h9, 1'b0, 1'b0, 1'b0, 3'h0, 3'h0);
      lhalf = 24.0;
      repeat (1000) @(posedge CLK_SYS);
      #1;
      chk(LINK_SLOW, 1'b0);
      $display("link speed test done");
   end
   endtask
   task conclude;
   begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   initial
   begin
      repeat (8) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      repeat (200) @(posedge CLK_SYS);
      for (i = 0; i < 11; i = i + 1) t_mcu(i[3:0], 1'b0);
      t_mcu(4'h0, 1'b1);
      t_leg(4'h1);
      t_leg(4'h9);
      t_fail;
      t_link;
      conclude;
   end
   // Runs should end well inside this span; reaching it means a hang.
   initial
   begin
      #400000;
      miscompares = miscompares + 1;
      conclude;
   end
endmodule
bind drss_seq drss_seq_props drss_seq_props_inst (
   .CLK_SYS(CLK_SYS), .RSTN(RSTN), .START(START), .STRATEGY(STRATEGY), .PROFILE_LEGACY(PROFILE_LEGACY),
   .LINK_SWD(LINK_SWD), .ACC_REQ(ACC_REQ), .ACC_WR(ACC_WR), .ACC_ADDR(ACC_ADDR), .ACC_WDATA(ACC_WDATA),
   .NRST_O(NRST_O), .NRST_OE_N(NRST_OE_N), .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL), .FAIL_CODE(FAIL_CODE),
   .LINK_SEL_SWD(LINK_SEL_SWD), .LINK_SLOW(LINK_SLOW));
